/* iev_pkg.sv */
// Purpose: Shared constants for the interrupt event slice (bits 22 to 6).
// Assumes: AXI4-Lite register access with 32-bit data and byte addresses.
// Notes:   Offsets and bit positions are used by the logic only by name.
`default_nettype none

package iev_pkg;

  // Register bus geometry.
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          STRB_W      = DATA_W / 8;

  // Byte addresses of the event and mask set/clear ports.
  localparam logic [7:0]  EV_SET_OFF  = 8'h80;
  localparam logic [7:0]  EV_CLR_OFF  = 8'h84;
  localparam logic [7:0]  MSK_SET_OFF = 8'h88;
  localparam logic [7:0]  MSK_CLR_OFF = 8'h8C;

  // Event bit positions.
  localparam int          BIT_LOST    = 22;
  localparam int          BIT_SECS    = 21;
  localparam int          BIT_NEWC    = 20;
  localparam int          BIT_PHY     = 19;
  localparam int          BIT_ACC     = 18;
  localparam int          BIT_BUSI    = 17;
  localparam int          BIT_IDD     = 16;
  localparam int          BIT_IDS     = 15;
  localparam int          BIT_LOCK    = 9;
  localparam int          BIT_POST    = 8;
  localparam int          BIT_ISORX   = 7;
  localparam int          BIT_ISOTX   = 6;

  // Latched bits that software may set or clear.
  localparam logic [31:0] EV_LATCHED  = 32'h007F_8300;
  // Every bit this slice implements; all others read as zero.
  localparam logic [31:0] EV_IMPL     = 32'h007F_83C0;
  // Reset values of the event and mask registers.
  localparam logic [31:0] EV_RESET    = 32'h0000_0000;
  localparam logic [31:0] MSK_RESET   = 32'h0000_0000;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Lost-cycle tracker states, one-hot.
  typedef enum logic [3:0] {
    LC_IDLE  = 4'h1,
    LC_GAP   = 4'h2,
    LC_START = 4'h4,
    LC_SEEN  = 4'h8
  } iev_lc_t;

endpackage

`default_nettype wire

/* iev_event_ctrl.sv */
// Purpose: Interrupt event register slice, bits 22 to 6, with its mask.
// Assumes: All event inputs are synchronous to mclk.
// Notes:   Reads of an event port return event AND mask.
// How it works
// - Missed cycle start between new cycles: lost.
// - Predict lost cycle from gaps after cycle.
// - Seconds bit seven change sets rollover.
// - Cycle count low bit toggle: new cycle.
// - PHY status interrupt request sets flag.
// - Access without PHY clock sets failure flag.
// - PHY bus reset entry sets init flag.
// - Self-ID stream done sets done flag.
// - Bus init set clears done flag.
// - Sticky done copy follows primary sets.
// - Bits 14 to 10 read zero.
// - Lock response without ack sets error.
// - Posted write bus error sets flag.
// - Receive summary: OR of event and mask.
// - Transmit summary: OR of event and mask.
// - Edge or set port sets; clear port clears.
// - Event read returns event AND mask.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`default_nettype none

module iev_event_ctrl #(
  parameter int NUM_RX = 4,  // Isochronous receive contexts.
  parameter int NUM_TX = 4   // Isochronous transmit contexts.
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // AXI4-Lite slave.
  input  wire logic                       awvalid,
  output var  logic                       awready,
  input  wire logic [iev_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       wvalid,
  output var  logic                       wready,
  input  wire logic [iev_pkg::DATA_W-1:0] wdata,
  input  wire logic [iev_pkg::STRB_W-1:0] wstrb,
  output var  logic                       bvalid,
  input  wire logic                       bready,
  output var  logic [1:0]                 bresp,
  input  wire logic                       arvalid,
  output var  logic                       arready,
  input  wire logic [iev_pkg::ADDR_W-1:0] araddr,
  output var  logic                       rvalid,
  input  wire logic                       rready,
  output var  logic [iev_pkg::DATA_W-1:0] rdata,
  output var  logic [1:0]                 rresp,
  // Event sources from the link core and PHY.
  input  wire logic                       cycleCountLsb,
  input  wire logic                       cycleSecondsBit7,
  input  wire logic                       cycleStartSeen,
  input  wire logic                       subactionGap,
  input  wire logic                       arbResetGap,
  input  wire logic                       phyStatusIrq,
  input  wire logic                       phyClkPresent,
  input  wire logic                       busResetState,
  input  wire logic                       selfIdStreamDone,
  input  wire logic                       lockAckMissing,
  input  wire logic                       postedWriteBusErr,
  // Per-context isochronous event and mask bits.
  input  wire logic [NUM_RX-1:0]          isoRxEvent,
  input  wire logic [NUM_RX-1:0]          isoRxMask,
  input  wire logic [NUM_TX-1:0]          isoTxEvent,
  input  wire logic [NUM_TX-1:0]          isoTxMask,
  // Level interrupt, high while an unmasked event is set.
  output var  logic                       irq
);
  import iev_pkg::*;

  // Refuse context counts that the register cannot describe.
  if (NUM_RX < 1 || NUM_RX > 32 || NUM_TX < 1 || NUM_TX > 32) begin : g_bad_cfg
    $error("NUM_RX and NUM_TX must lie between 1 and 32.");
  end

  // The whole state of the block in one word.
  typedef struct packed {
    logic [31:0]        ev;       // Latched event bits.
    logic [31:0]        mask;     // Interrupt mask.
    logic [4:0]         srcPrev;  // Previous source levels.
    logic               cntPrev;  // Previous cycle count low bit.
    logic               secPrev;  // Previous seconds bit seven.
    iev_lc_t            lc;       // Lost-cycle tracker.
    logic               awHeld;   // Write address captured.
    logic               wHeld;    // Write data captured.
    logic [ADDR_W-1:0]  awAddr;
    logic [DATA_W-1:0]  wData;
    logic [STRB_W-1:0]  wStrb;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [DATA_W-1:0]  rdata;
    logic [1:0]         rresp;
    logic               irq;
  } iev_state_t;

  // Reset image; the bus is ready to accept from the first edge.
  localparam iev_state_t ST_RESET = '{
    ev: EV_RESET, mask: MSK_RESET, srcPrev: 5'h0, cntPrev: 1'b0,
    secPrev: 1'b0, lc: LC_IDLE, awHeld: 1'b0, wHeld: 1'b0,
    awAddr: '0, wData: '0, wStrb: '0, awready: 1'b1, wready: 1'b1,
    bvalid: 1'b0, bresp: RESP_OKAY, arready: 1'b1, rvalid: 1'b0,
    rdata: '0, rresp: RESP_OKAY, irq: 1'b0};

  iev_state_t        st_reg;     // Registered state.
  iev_state_t        st_next;    // Next state.
  logic [4:0]        srcNow;     // Edge-detected sources, current.
  logic [4:0]        rise;       // Asserting edges this cycle.
  logic              newCycle;   // Cycle count low bit toggled.
  logic              lostNow;    // Lost cycle seen or predicted.
  logic [31:0]       hwSet;      // Hardware set requests.
  logic [31:0]       swSet;      // Software set requests.
  logic [31:0]       swClr;      // Software clear requests.
  logic [31:0]       setAll;     // Combined sets.
  logic [31:0]       summary;    // Unlatched isochronous bits.
  logic [31:0]       wrBits;     // Write data under byte strobes.
  logic              doWrite;    // Captured write is performed.
  logic              rdTaken;    // Read address taken.

  // Expand byte strobes into a bit mask.
  function automatic logic [DATA_W-1:0] strbBits(input logic [STRB_W-1:0] s);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // Full event view: latched bits plus summaries, limited to this slice.
  function automatic logic [31:0] evView(input logic [31:0] ev,
                                         input logic [31:0] sum);
    return (ev | sum) & EV_IMPL;
  endfunction

  // Next-state logic.
  always_comb begin
    st_next = st_reg;
    hwSet   = '0;
    swSet   = '0;
    swClr   = '0;
    lostNow = 1'b0;
    wrBits  = st_reg.wData & strbBits(st_reg.wStrb);

    srcNow = {phyStatusIrq, busResetState, selfIdStreamDone,
              lockAckMissing, postedWriteBusErr};
    rise   = srcNow & ~st_reg.srcPrev;
    st_next.srcPrev = srcNow;

    newCycle = cycleCountLsb ^ st_reg.cntPrev;
    st_next.cntPrev = cycleCountLsb;
    hwSet[BIT_NEWC] = newCycle;

    hwSet[BIT_SECS] = cycleSecondsBit7 ^ st_reg.secPrev;
    st_next.secPrev = cycleSecondsBit7;

    // Lost-cycle tracker. A prediction returns to idle, or to gap if a new
    // cycle comes with it, so that the following new cycle does not report the same loss twice.
    unique case (st_reg.lc)
      LC_IDLE: begin
        if (newCycle) begin
          st_next.lc = LC_GAP;
        end
      end
      LC_GAP: begin
        if (newCycle) begin
          lostNow = 1'b1;
        end else if (cycleStartSeen) begin
          st_next.lc = LC_SEEN;
        end else if (arbResetGap) begin
          lostNow    = 1'b1;
          st_next.lc = LC_IDLE;
        end else if (subactionGap) begin
          st_next.lc = LC_START;
        end
      end
      LC_START: begin
        if (cycleStartSeen) begin
          st_next.lc = LC_SEEN;
        end else begin
          lostNow    = 1'b1;
          st_next.lc = newCycle ? LC_GAP : LC_IDLE;
        end
      end
      LC_SEEN: begin
        if (newCycle) begin
          st_next.lc = LC_GAP;
        end
      end
      default: st_next.lc = LC_IDLE;  // Illegal code recovers to idle.
    endcase
    hwSet[BIT_LOST] = lostNow;

    hwSet[BIT_PHY]  = rise[4];
    hwSet[BIT_BUSI] = rise[3];
    hwSet[BIT_IDD]  = rise[2];
    hwSet[BIT_LOCK] = rise[1];
    hwSet[BIT_POST] = rise[0];

    summary = '0;
    summary[BIT_ISORX] = |(isoRxEvent & isoRxMask);
    summary[BIT_ISOTX] = |(isoTxEvent & isoTxMask);

    // Write channel: address and data are captured in either order.
    if (awvalid && st_reg.awready) begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = awaddr;
    end
    if (wvalid && st_reg.wready) begin
      st_next.wHeld = 1'b1;
      st_next.wData = wdata;
      st_next.wStrb = wstrb;
    end
    doWrite = st_reg.awHeld && st_reg.wHeld && !st_reg.bvalid;
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (doWrite) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = RESP_OKAY;
      unique case (st_reg.awAddr)
        EV_SET_OFF:  swSet = wrBits & EV_LATCHED;
        EV_CLR_OFF:  swClr = wrBits & EV_LATCHED;
        MSK_SET_OFF: st_next.mask = st_reg.mask | (wrBits & EV_IMPL);
        MSK_CLR_OFF: st_next.mask = st_reg.mask & ~(wrBits & EV_IMPL);
        default:     st_next.bresp = RESP_SLVERR;
      endcase
    end
    st_next.awready = !st_next.awHeld;
    st_next.wready  = !st_next.wHeld;

    // Read channel: one read at a time, answered on the next edge.
    rdTaken = arvalid && st_reg.arready;
    if (st_reg.rvalid && rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end
    if (rdTaken) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = RESP_OKAY;
      unique case (araddr)
        // event AND mask; reserved bits fall to zero.
        EV_SET_OFF, EV_CLR_OFF: begin
          st_next.rdata = evView(st_reg.ev, summary) & st_reg.mask;
        end
        MSK_SET_OFF, MSK_CLR_OFF: st_next.rdata = st_reg.mask;
        default: begin
          st_next.rdata = '0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // access without PHY clock. The flag lands on the edge that
    // issues the answer, so the next access already sees it.
    hwSet[BIT_ACC] = (doWrite || rdTaken) && !phyClkPresent;

    setAll = hwSet | swSet;
    setAll[BIT_IDS] = setAll[BIT_IDS] | setAll[BIT_IDD];
    st_next.ev = ((st_reg.ev & ~swClr) | setAll) & EV_LATCHED;
    if (setAll[BIT_BUSI]) begin
      st_next.ev[BIT_IDD] = 1'b0;
    end

    // Interrupt level from the new event and mask values.
    st_next.irq = |(evView(st_next.ev, summary) & st_next.mask);
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output comes straight from the state register.
  assign awready = st_reg.awready;
  assign wready  = st_reg.wready;
  assign bvalid  = st_reg.bvalid;
  assign bresp   = st_reg.bresp;
  assign arready = st_reg.arready;
  assign rvalid  = st_reg.rvalid;
  assign rdata   = st_reg.rdata;
  assign rresp   = st_reg.rresp;
  assign irq     = st_reg.irq;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Two new cycles with no start between them.
  sequence s_gap_newc;
    st_reg.lc == LC_GAP && newCycle;
  endsequence
  // Gap passed and no start on the next cycle.
  sequence s_gap_nostart;
    st_reg.lc == LC_GAP && subactionGap && !newCycle && !cycleStartSeen
      && !arbResetGap ##1 !cycleStartSeen;
  endsequence

  a_lost_missed: assert property (s_gap_newc |=> st_reg.ev[BIT_LOST])
    else $error("Lost cycle not flagged after two new cycles.");
  a_lost_predict: assert property (s_gap_nostart |=> st_reg.ev[BIT_LOST])
    else $error("Predicted lost cycle not flagged.");
  a_secs_flip: assert property ((cycleSecondsBit7 != st_reg.secPrev)
      |=> st_reg.ev[BIT_SECS])
    else $error("Seconds rollover not flagged.");
  a_newc_toggle: assert property ((cycleCountLsb != st_reg.cntPrev)
      |=> st_reg.ev[BIT_NEWC])
    else $error("New cycle not flagged.");
  a_phy_edge: assert property ((phyStatusIrq && !st_reg.srcPrev[4])
      |=> st_reg.ev[BIT_PHY])
    else $error("PHY request not flagged.");
  a_acc_fail: assert property ((arvalid && arready && !phyClkPresent)
      |=> rvalid && st_reg.ev[BIT_ACC])
    else $error("Access failure not flagged with the answer.");
  a_busi_clear: assert property ((busResetState && !st_reg.srcPrev[3])
      |=> st_reg.ev[BIT_BUSI] && !st_reg.ev[BIT_IDD])
    else $error("Bus init did not clear self-ID done.");
  a_ids_sticky: assert property ($rose(st_reg.ev[BIT_IDD])
      |-> st_reg.ev[BIT_IDS])
    else $error("Sticky self-ID copy not set.");
  a_rsvd_zero: assert property (rvalid |-> rdata[14:10] == 5'h00)
    else $error("Reserved bits read nonzero.");
  a_sum_unlatched: assert property (st_reg.ev[BIT_ISORX:BIT_ISOTX] == 2'b00)
    else $error("Summary bits were latched.");
  a_rd_masked: assert property ((arvalid && arready && araddr == EV_SET_OFF)
      |=> (rdata & ~$past(st_reg.mask)) == '0)
    else $error("Event read not gated by mask.");
  // The receive summary must follow the live context levels, not a latch.
  a_rx_summary: assert property ((arvalid && arready && araddr == EV_SET_OFF)
      |=> rdata[BIT_ISORX]
          == $past(st_reg.mask[BIT_ISORX] && (|(isoRxEvent & isoRxMask))))
    else $error("Receive summary not read from live context levels.");

endmodule

`default_nettype wire

/* test_iev_event_ctrl.sv */
// Purpose: Self-checking bench for the interrupt event slice and its mask.
// Assumes: AXI4-Lite master tasks; every input changes by NBA at a rising edge.
// Notes:   Ready and valid are sampled at the falling edge, where they are settled.
`default_nettype none

module test_iev_event_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import iev_pkg::*;

  // Source bits inside srcs, one per event input except phyClkPresent, which phyClk drives.
  localparam logic [9:0] S_CNT = 10'h001;
  localparam logic [9:0] S_SEC = 10'h002;
  localparam logic [9:0] S_STA = 10'h004;
  localparam logic [9:0] S_SUB = 10'h008;
  localparam logic [9:0] S_ARB = 10'h010;
  localparam logic [9:0] S_PHY = 10'h020;
  localparam logic [9:0] S_BUS = 10'h040;
  localparam logic [9:0] S_IDD = 10'h080;
  localparam logic [9:0] S_LCK = 10'h100;
  localparam logic [9:0] S_PST = 10'h200;

  logic        mclk;            // Bench clock, 4 ns.
  logic        rst_n;           // Active-low reset.
  logic        awvalid;         // Write address valid.
  logic        awready;         // Write address ready.
  logic        wvalid;          // Write data valid.
  logic        wready;          // Write data ready.
  logic        bvalid;          // Write response valid.
  logic        bready;          // Write response ready.
  logic        arvalid;         // Read address valid.
  logic        arready;         // Read address ready.
  logic        rvalid;          // Read data valid.
  logic        rready;          // Read data ready.
  logic        irq;             // Level interrupt.
  logic        phyClk;          // PHY clock present.
  logic [7:0]  awaddr;          // Write address.
  logic [7:0]  araddr;          // Read address.
  logic [31:0] wdata;           // Write data.
  logic [31:0] rdata;           // Read data.
  logic [3:0]  wstrb;           // Write strobes.
  logic [3:0]  wrStrb;          // Strobes that the next write offers.
  logic [1:0]  bresp;           // Write response code.
  logic [1:0]  rresp;           // Read response code.
  logic [3:0]  isoRxEv;         // Receive context events.
  logic [3:0]  isoRxMk;         // Receive context masks.
  logic [3:0]  isoTxEv;         // Transmit context events.
  logic [3:0]  isoTxMk;         // Transmit context masks.
  logic [9:0]  srcs;            // Event source levels.
  logic [31:0] rv;              // Scratch read data.
  logic [1:0]  rr;              // Scratch response.
  int          n_mismatch;      // Mismatches seen.
  int          total_checks;    // Comparisons made.
  logic [9:0]  tSrc [3] = '{S_PHY, S_LCK, S_PST};
  int          tBit [5] = '{BIT_PHY, BIT_LOCK, BIT_POST, BIT_SECS, BIT_SECS};
  logic [31:0] lcExp [4] = '{32'h0050_0000, 32'h0040_0000, 32'h0040_0000, 32'h0010_0000};

  // Free-running clock.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  iev_event_ctrl #(.NUM_RX(4), .NUM_TX(4)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .cycleCountLsb(srcs[0]), .cycleSecondsBit7(srcs[1]), .cycleStartSeen(srcs[2]),
    .subactionGap(srcs[3]), .arbResetGap(srcs[4]), .phyStatusIrq(srcs[5]),
    .phyClkPresent(phyClk), .busResetState(srcs[6]), .selfIdStreamDone(srcs[7]),
    .lockAckMissing(srcs[8]), .postedWriteBusErr(srcs[9]), .isoRxEvent(isoRxEv),
    .isoRxMask(isoRxMk), .isoTxEvent(isoTxEv), .isoTxMask(isoTxMk), .irq(irq));

  // Compare and count; the unknown never matches.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic timeout;
    n_mismatch++;
    $display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    finish_test();
  endtask

  // One write; address and data offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, dd, bd, sa, sw, sb;
    logic [1:0] sr;
    @(posedge mclk);
    ad = 1'b0;
    dd = 1'b0;
    bd = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= wrStrb;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !bd; n++) begin
      @(negedge mclk);
      sa = awready;
      sw = wready;
      sb = bvalid;
      sr = bresp;
      @(posedge mclk);
      if (sa === 1'b1 && !ad) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (sw === 1'b1 && !dd) begin
        wvalid <= 1'b0;
        dd = 1'b1;
      end
      if (sb === 1'b1) begin
        bready <= 1'b0;
        bd = 1'b1;
        r = sr;
      end
    end
    if (!bd) timeout();
  endtask

  // One read; rready held until rvalid is sampled.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ad, dn, sa, sv;
    logic [31:0] sd;
    logic [1:0] sr;
    @(posedge mclk);
    ad = 1'b0;
    dn = 1'b0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(negedge mclk);
      sa = arready;
      sv = rvalid;
      sd = rdata;
      sr = rresp;
      @(posedge mclk);
      if (sa === 1'b1 && !ad) begin
        arvalid <= 1'b0;
        ad = 1'b1;
      end
      if (sv === 1'b1) begin
        rready <= 1'b0;
        dn = 1'b1;
        d = sd;
        r = sr;
      end
    end
    if (!dn) timeout();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rv, rr);
    chk(rv, e);
  endtask

  task automatic clr_all;
    wr(EV_CLR_OFF, 32'hFFFF_FFFF, rr);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // Sources: pulse raises for one cycle, tgl flips a level.
  task automatic pulse(input logic [9:0] m);
    @(posedge mclk);
    srcs <= srcs | m;
    @(posedge mclk);
    srcs <= srcs & ~m;
  endtask

  task automatic tgl(input logic [9:0] m);
    @(posedge mclk);
    srcs <= srcs ^ m;
  endtask

  // Hang guard, well beyond the main sequence.
  initial begin
    repeat (20000) @(posedge mclk);
    timeout();
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb, srcs} = '0;
    {isoRxEv, isoRxMk, isoTxEv, isoTxMk} = 16'h0000;
    phyClk = 1'b1;
    wrStrb = 4'hF;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(EV_SET_OFF, EV_RESET & MSK_RESET);
    rd_chk(MSK_SET_OFF, MSK_RESET);
    chk_irq(1'b0);
    wr(MSK_SET_OFF, 32'hFFFF_FFFF, rr);
    chk({30'h0, rr}, {30'h0, RESP_OKAY});
    rd_chk(MSK_CLR_OFF, EV_IMPL);
    $display("test reset_mask done");
    // set and clear ports; reserved and summary bits stay zero.
    wr(EV_SET_OFF, 32'hFFFD_FFFF, rr);
    rd_chk(EV_SET_OFF, 32'h007D_8300);
    rd_chk(EV_CLR_OFF, 32'h007D_8300);
    chk_irq(1'b1);
    wr(EV_CLR_OFF, 32'h0008_0000, rr);
    rd_chk(EV_SET_OFF, 32'h0075_8300);
    clr_all();
    rd_chk(EV_SET_OFF, 32'h0);
    chk_irq(1'b0);
    // Only byte one is strobed, so only bits 15, 9 and 8 may be set.
    wrStrb = 4'h2;
    wr(EV_SET_OFF, 32'hFFFF_FFFF, rr);
    wrStrb = 4'hF;
    rd_chk(EV_SET_OFF, 32'h0000_8300);
    clr_all();
    $display("test set_clear done");
    // edge-set flags, one table entry per source; seconds bit seven has two, one per toggle direction.
    for (int i = 0; i < 5; i++) begin
      if (i < 3) pulse(tSrc[i]);
      else tgl(S_SEC);
      rd_chk(EV_SET_OFF, 32'h1 << tBit[i]);
      chk_irq(1'b1);
      clr_all();
    end
    pulse(S_IDD);
    rd_chk(EV_SET_OFF, 32'h0001_8000);
    pulse(S_BUS);
    rd_chk(EV_SET_OFF, 32'h0002_8000);
    clr_all();
    $display("test edge_sources done");
    // access while the PHY clock is missing.
    @(posedge mclk);
    phyClk <= 1'b0;
    rd(MSK_SET_OFF, rv, rr);
    chk(rv, EV_IMPL);
    @(posedge mclk);
    phyClk <= 1'b1;
    rd_chk(EV_SET_OFF, 32'h0004_0000);
    clr_all();
    $display("test access_fail done");
    // lost cycle: missed start, arb gap, gap without start, gap with start.
    for (int k = 0; k < 4; k++) begin
      pulse(S_STA);
      tgl(S_CNT);
      clr_all();
      case (k)
        0: tgl(S_CNT);
        1: pulse(S_ARB);
        2: pulse(S_SUB);
        default: begin
          pulse(S_SUB | S_STA);
          tgl(S_CNT);
        end
      endcase
      rd_chk(EV_SET_OFF, lcExp[k]);
      clr_all();
    end
    $display("test lost_cycle done");
    // summaries follow context event and mask levels.
    @(posedge mclk);
    {isoRxEv, isoRxMk, isoTxEv, isoTxMk} <= 16'h4288;
    rd_chk(EV_SET_OFF, 32'h0000_0040);
    @(posedge mclk);
    isoRxMk <= 4'h6;
    wr(EV_CLR_OFF, 32'h0000_00C0, rr);
    rd_chk(EV_SET_OFF, 32'h0000_00C0);
    chk_irq(1'b1);
    @(posedge mclk);
    {isoRxEv, isoRxMk, isoTxEv, isoTxMk} <= 16'h0000;
    wr(EV_SET_OFF, 32'h0000_00C0, rr);
    rd_chk(EV_SET_OFF, 32'h0);
    $display("test summaries done");
    // masked events read as zero and hold irq low.
    wr(EV_SET_OFF, 32'h0008_0100, rr);
    wr(MSK_CLR_OFF, 32'h0008_0100, rr);
    rd_chk(EV_SET_OFF, 32'h0);
    rd_chk(MSK_SET_OFF, 32'h0077_82C0);
    chk_irq(1'b0);
    wr(MSK_SET_OFF, 32'h0000_0100, rr);
    rd_chk(EV_CLR_OFF, 32'h0000_0100);
    chk_irq(1'b1);
    wr(8'h40, 32'hFFFF_FFFF, rr);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    rd(8'h40, rv, rr);
    chk(rv, 32'h0);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    $display("test mask_unmapped done");
    finish_test();
  end
endmodule

`default_nettype wire
